// ===== logic/cts_pkg.sv
// Purpose: constants and types for the transmit channel scheduler
// Assumes: 250 MHz system clock, one 11-bit CAN identifier space
// Notes: register address is {object index[15:0], sub-index[7:0]}
// Function
// - eight transmit channels, eight bytes each
// - comm record sub-index 0 reads five
// - reset identifiers 180h..480h plus node, else zero
// - frame identifier is configured sub-index 1
// - bit 31 disables, bits 10..0 identifier
// - type 0 sends once after SYNC
// - type N sends every Nth SYNC
// - type 252 latches on SYNC, sends on remote
// - type 253 refreshes and sends on remote
// - type 254 sends on event timer
// - type 255 sends on change or timer
// - sub-index 3 inhibit gap in 100us
// - sub-index 5 event timer in 1ms
// - event timer resolution no finer than 1ms
// - map count: zero disables, one to eight
// - entry: index 16, sub-index 8, size 8
// - at most eight objects, eight bytes
// - entries writable only while count is zero
// - SYNC identifier object rw, default 80h
// - frames only in operational state
package cts_pkg;
    localparam int CTS_CLK_NS = 4;
    localparam int CTS_INH_UNIT_NS = 100000;
    localparam int CTS_EVT_UNIT_NS = 1000000;
    localparam int CTS_INH_UNIT_CYC = CTS_INH_UNIT_NS / CTS_CLK_NS;
    localparam int CTS_INH_PER_MS = CTS_EVT_UNIT_NS / CTS_INH_UNIT_NS;
    localparam logic [15:0] CTS_IDX_SYNC = 16'h1015;
    localparam logic [15:0] CTS_IDX_COMM = 16'h1800;
    localparam logic [15:0] CTS_IDX_MAP = 16'h1a00;
    localparam logic [31:0] CTS_SYNC_RST = 32'h00000080;
    localparam logic [31:0] CTS_COBID_BASE = 32'h00000180;
    localparam logic [31:0] CTS_COBID_STEP = 32'h00000100;
    localparam int CTS_COBID_DEF_CH = 4;
    localparam logic [7:0] CTS_LAST_SUB = 8'h05;
    localparam logic [7:0] CTS_TT_RST = 8'hfe;
    localparam logic [7:0] CTS_TT_SYNC_MAX = 8'hf0;
    localparam logic [7:0] CTS_TT_SYNC_RTR = 8'hfc;
    localparam logic [7:0] CTS_TT_RTR = 8'hfd;
    localparam logic [7:0] CTS_TT_EVT = 8'hfe;
    localparam logic [7:0] CTS_TT_COS = 8'hff;
    localparam int CTS_DIS_BIT = 31;
    localparam int CTS_ID_W = 11;
    localparam int CTS_MAX_OBJ = 8;
    localparam int CTS_MAX_BYTES = 8;
    localparam int CTS_IMG_BYTES = 64;
    localparam logic [7:0] CTS_SUB_COBID = 8'h01;
    localparam logic [7:0] CTS_SUB_TYPE = 8'h02;
    localparam logic [7:0] CTS_SUB_INH = 8'h03;
    localparam logic [7:0] CTS_SUB_EVT = 8'h05;
    typedef struct packed {
        logic [10:0] id;
        logic [3:0] dlc;
        logic [63:0] data;
    } cts_frame_type;
endpackage

// ===== logic/cts_transmit_channel_sched.sv
// Purpose: decide when each transmit channel sends and build its payload
// Assumes: rx strobe marks one received frame; image holds 64 object bytes
// Notes: mapped index low six bits pick the image byte offset
// Notes: type 0 sends once per arming, armed by a retype or a payload change
// Notes: inhibit and event timers share one free-running prescaler, 100us ticks and 1ms ticks
module cts_transmit_channel_sched
    import cts_pkg::*;
#(
    parameter int CH = 8,
    parameter int INH_UNIT_CYC = CTS_INH_UNIT_CYC
) (
    input wire logic i_clk, // system clock
    input wire logic i_reset, // sync reset, high
    input wire logic [6:0] i_node_id, // node number
    input wire logic i_operational, // network state operational
    input wire logic [23:0] i_addr, // {index, sub-index}
    input wire logic [31:0] i_wdata, // write data
    input wire logic i_wr, // write strobe
    input wire logic i_rd, // read strobe
    output logic [31:0] o_rdata, // read data, next cycle
    input wire logic i_rx_valid, // received frame strobe
    input wire logic [10:0] i_rx_id, // received identifier
    input wire logic i_rx_rtr, // received remote request
    input wire logic [CTS_IMG_BYTES*8-1:0] i_image, // object bytes
    output logic o_tx_valid, // frame offered
    output cts_frame_type o_tx, // frame content
    input wire logic i_tx_ready // controller takes frame
);
    // channel number is three address bits, so more than eight cannot decode
    // one to eight channels, eight bytes each
    if (CH < 1 || CH > CTS_MAX_OBJ) begin : g_chk
        $error("channel count out of range");
    end
    if (INH_UNIT_CYC < 2) begin : g_chk2
        $error("inhibit unit too short");
    end

    logic [31:0] sync_id_q;
    logic [31:0] cobid_q [CH];
    logic [7:0] ttype_q [CH];
    logic [15:0] inh_q [CH];
    logic [15:0] evt_q [CH];
    logic [3:0] cnt_q [CH];
    logic [31:0] map_q [CH][CTS_MAX_OBJ];
    logic [15:0] a_idx;
    logic [7:0] a_sub;
    logic [2:0] a_ch;
    logic a_comm;
    logic a_map;
    logic [31:0] rd_d;

    // address decode
    // channel is the low three index bits; absent channels read zero
    assign a_idx = i_addr[23:8];
    assign a_sub = i_addr[7:0];
    assign a_ch = a_idx[2:0];
    assign a_comm = a_idx[15:3] == CTS_IDX_COMM[15:3] && 32'(a_ch) < CH;
    assign a_map = a_idx[15:3] == CTS_IDX_MAP[15:3] && 32'(a_ch) < CH;

    // configuration writes
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sync_id_q <= CTS_SYNC_RST;
            for (int c = 0; c < CH; c++) begin
                cobid_q[c] <= (c < CTS_COBID_DEF_CH) ?
                    CTS_COBID_BASE + CTS_COBID_STEP * 32'(c) + 32'(i_node_id) : '0;
                ttype_q[c] <= CTS_TT_RST;
                inh_q[c] <= '0;
                evt_q[c] <= '0;
                cnt_q[c] <= '0;
                for (int e = 0; e < CTS_MAX_OBJ; e++) begin
                    map_q[c][e] <= '0;
                end
            end
        end else if (i_wr) begin
            if (a_idx == CTS_IDX_SYNC && a_sub == '0) begin
                sync_id_q <= i_wdata;
            end
            if (a_comm) begin
                if (a_sub == CTS_SUB_COBID) begin
                    cobid_q[a_ch] <= {i_wdata[CTS_DIS_BIT], 20'h0, i_wdata[10:0]};
                end
                if (a_sub == CTS_SUB_TYPE) begin
                    ttype_q[a_ch] <= i_wdata[7:0];
                end
                if (a_sub == CTS_SUB_INH) begin
                    inh_q[a_ch] <= i_wdata[15:0];
                end
                if (a_sub == CTS_SUB_EVT) begin
                    evt_q[a_ch] <= i_wdata[15:0];
                end
            end
            if (a_map) begin
                // a larger count is dropped and the old mapping stays live
                // count at most eight
                if (a_sub == '0 && i_wdata <= 32'(CTS_MAX_OBJ)) begin
                    cnt_q[a_ch] <= i_wdata[3:0];
                end
                if (a_sub != '0 && a_sub <= 8'(CTS_MAX_OBJ) && cnt_q[a_ch] == '0) begin
                    map_q[a_ch][3'(a_sub - 8'h01)] <= i_wdata;
                end
            end
        end
    end

    // read mux
    always_comb begin
        rd_d = '0;
        if (a_idx == CTS_IDX_SYNC && a_sub == '0) begin
            rd_d = sync_id_q;
        end
        if (a_comm) begin
            unique case (a_sub)
                8'h00: rd_d = 32'(CTS_LAST_SUB);
                CTS_SUB_COBID: rd_d = cobid_q[a_ch];
                CTS_SUB_TYPE: rd_d = 32'(ttype_q[a_ch]);
                CTS_SUB_INH: rd_d = 32'(inh_q[a_ch]);
                CTS_SUB_EVT: rd_d = 32'(evt_q[a_ch]);
                default: rd_d = '0;
            endcase
        end
        if (a_map) begin
            if (a_sub == '0) begin
                rd_d = 32'(cnt_q[a_ch]);
            end else if (a_sub <= 8'(CTS_MAX_OBJ)) begin
                rd_d = map_q[a_ch][3'(a_sub - 8'h01)];
            end
        end
    end

    // read data register
    // holds until the next read strobe
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            o_rdata <= rd_d;
        end
    end

    logic [$clog2(INH_UNIT_CYC)-1:0] pre_q;
    logic [3:0] ms_q;
    logic tick_q;
    logic ms_tick_q;

    // 100us and 1ms ticks
    // shared by every channel, never restarted by a register write,
    // so a freshly enabled timer first counts on the next whole tick
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pre_q <= '0;
            ms_q <= '0;
            tick_q <= 1'b0;
            ms_tick_q <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            ms_tick_q <= 1'b0;
            pre_q <= pre_q + 1'b1;
            if (32'(pre_q) == INH_UNIT_CYC - 1) begin
                pre_q <= '0;
                tick_q <= 1'b1;
                ms_q <= ms_q + 1'b1;
                if (32'(ms_q) == CTS_INH_PER_MS - 1) begin
                    ms_q <= '0;
                    ms_tick_q <= 1'b1;
                end
            end
        end
    end

    logic [CH-1:0] evt_fire_q;

    // per channel event timer
    for (genvar g = 0; g < CH; g++) begin : g_evt
        logic [15:0] ecnt_q;
        logic asyn;
        assign asyn = ttype_q[g] == CTS_TT_EVT || ttype_q[g] == CTS_TT_COS;
        always_ff @(posedge i_clk) begin
            if (i_reset) begin
                ecnt_q <= '0;
                evt_fire_q[g] <= 1'b0;
            end else begin
                evt_fire_q[g] <= 1'b0;
                // restarts only on expiry or while switched off
                // whole ms periods
                if (!asyn || evt_q[g] == '0 || !i_operational) begin
                    ecnt_q <= '0;
                end else if (ms_tick_q) begin
                    ecnt_q <= ecnt_q + 1'b1;
                    if (ecnt_q + 16'h1 >= evt_q[g]) begin
                        ecnt_q <= '0;
                        evt_fire_q[g] <= 1'b1;
                    end
                end
            end
        end
    end

    logic [2:0] ch_q;
    logic [63:0] bld_data;
    logic [3:0] bld_dlc;
    logic bld_ok;
    logic en;
    logic go;
    logic is_sync;
    logic [7:0] ty;

    always_comb begin
        int pos;
        int nb;
        int bits;
        logic [5:0] off;
        // every loop variable starts cleared so nothing is held over
        // sizes must be whole bytes, one to four; others block the channel
        pos = 0;
        bits = 0;
        nb = 0;
        off = '0;
        bld_data = '0;
        bld_ok = 1'b1;
        for (int e = 0; e < CTS_MAX_OBJ; e++) begin
            off = map_q[ch_q][e][21:16];
            nb = int'(map_q[ch_q][e][7:3]);
            if (e < int'(cnt_q[ch_q])) begin
                bits = bits + int'(map_q[ch_q][e][7:0]);
                if (map_q[ch_q][e][2:0] != '0 || nb == 0 || nb > 4) begin
                    bld_ok = 1'b0;
                end
                for (int b = 0; b < 4; b++) begin
                    if (b < nb && pos < CTS_MAX_BYTES) begin
                        bld_data[pos*8 +: 8] = i_image[int'(6'(off + 6'(b)))*8 +: 8];
                        pos = pos + 1;
                    end
                end
            end
        end
        if (bits > CTS_MAX_BYTES * 8) begin
            bld_ok = 1'b0;
        end
        bld_dlc = 4'(pos);
    end

    logic [CH-1:0] sync_pend_q;
    logic [CH-1:0] rtr_pend_q;
    logic [CH-1:0] evt_pend_q;
    logic [CH-1:0] latch_pend_q;
    // type 0 arming: set on retype or payload change, spent by a send
    logic [CH-1:0] arm_q;
    logic [7:0] scnt_q [CH];
    // one count more than the setting so a free tick never shortens the gap
    logic [16:0] icnt_q [CH];
    logic [63:0] latched_q [CH];
    logic [63:0] last_q [CH];

    // a frame held for the taker stalls sending on every channel;
    // a trigger waits in its flag until the scan comes round
    // channel may send
    assign ty = ttype_q[ch_q];
    assign en = i_operational && !cobid_q[ch_q][CTS_DIS_BIT] && cnt_q[ch_q] != '0 && bld_ok;
    // sync frame recognised by identifier with the remote flag clear
    assign is_sync = i_rx_valid && !i_rx_rtr && i_rx_id == sync_id_q[CTS_ID_W-1:0];
    assign go = en && icnt_q[ch_q] == '0 && (!o_tx_valid || i_tx_ready) &&
        (sync_pend_q[ch_q] || rtr_pend_q[ch_q] || evt_pend_q[ch_q] ||
        (ty == CTS_TT_COS && bld_data != last_q[ch_q]));

    // scan, send, then record new events
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ch_q <= '0;
            o_tx_valid <= 1'b0;
            o_tx <= '0;
            sync_pend_q <= '0;
            rtr_pend_q <= '0;
            evt_pend_q <= '0;
            latch_pend_q <= '0;
            arm_q <= '0;
            for (int c = 0; c < CH; c++) begin
                scnt_q[c] <= '0;
                icnt_q[c] <= '0;
                latched_q[c] <= '0;
                last_q[c] <= '0;
            end
        end else begin
            ch_q <= (32'(ch_q) == CH - 1) ? '0 : ch_q + 3'h1;
            if (o_tx_valid && i_tx_ready) begin
                o_tx_valid <= 1'b0;
            end
            // every channel counts down together on the shared tick
            // inhibit countdown
            for (int c = 0; c < CH; c++) begin
                if (tick_q && icnt_q[c] != '0) begin
                    icnt_q[c] <= icnt_q[c] - 17'h1;
                end
            end
            // taken when the scan reaches the channel, a few cycles after sync
            // latch on sync
            if (latch_pend_q[ch_q]) begin
                latched_q[ch_q] <= bld_data;
                latch_pend_q[ch_q] <= 1'b0;
            end
            // payload change re-arms a type 0 channel
            // a send below spends it, so the sent data never re-arm
            if (ty == '0 && bld_data != last_q[ch_q]) begin
                arm_q[ch_q] <= 1'b1;
            end
            if (go) begin
                o_tx_valid <= 1'b1;
                arm_q[ch_q] <= 1'b0;
                o_tx.id <= cobid_q[ch_q][CTS_ID_W-1:0];
                o_tx.dlc <= bld_dlc;
                o_tx.data <= (ty == CTS_TT_SYNC_RTR) ? latched_q[ch_q] : bld_data;
                last_q[ch_q] <= bld_data;
                // gap of whole units whatever the tick phase
                icnt_q[ch_q] <= (inh_q[ch_q] == '0) ? '0 : 17'(inh_q[ch_q]) + 17'h1;
                sync_pend_q[ch_q] <= 1'b0;
                rtr_pend_q[ch_q] <= 1'b0;
                evt_pend_q[ch_q] <= 1'b0;
            end
            for (int c = 0; c < CH; c++) begin
                if (evt_fire_q[c]) begin
                    evt_pend_q[c] <= 1'b1;
                end
                if (is_sync) begin
                    // one send on the first sync after arming
                    if (ttype_q[c] == '0 && arm_q[c]) begin
                        sync_pend_q[c] <= 1'b1;
                    end
                    if (ttype_q[c] != '0 && ttype_q[c] <= CTS_TT_SYNC_MAX) begin
                        scnt_q[c] <= scnt_q[c] + 8'h1;
                        if (scnt_q[c] + 8'h1 >= ttype_q[c]) begin
                            scnt_q[c] <= '0;
                            sync_pend_q[c] <= 1'b1;
                        end
                    end
                    if (ttype_q[c] == CTS_TT_SYNC_RTR) begin
                        latch_pend_q[c] <= 1'b1;
                    end
                end
                // other transmission types ignore remote requests
                // remote request
                if (i_rx_valid && i_rx_rtr && i_rx_id == cobid_q[c][CTS_ID_W-1:0] &&
                    (ttype_q[c] == CTS_TT_SYNC_RTR || ttype_q[c] == CTS_TT_RTR)) begin
                    rtr_pend_q[c] <= 1'b1;
                end
                // restart count and arm on retype
                if (i_wr && a_comm && 32'(a_ch) == c && a_sub == CTS_SUB_TYPE) begin
                    scnt_q[c] <= '0;
                    arm_q[c] <= 1'b1;
                end
                // placed last so it beats any trigger of the same cycle:
                // a sync taken while stopped must not fire on restart
                // no send trigger queued outside operational
                if (!i_operational) begin
                    sync_pend_q[c] <= 1'b0;
                    rtr_pend_q[c] <= 1'b0;
                    evt_pend_q[c] <= 1'b0;
                end
            end
        end
    end
endmodule // cts_transmit_channel_sched

// ===== bench/cts_sched_chk.sv
// Purpose: port assertions for the transmit channel scheduler
// Assumes: only the top module ports are visible
// Notes: bound to every scheduler instance
module cts_sched_chk
    import cts_pkg::*;
(
    input wire logic i_clk, // clock
    input wire logic i_reset, // sync reset
    input wire logic i_operational, // network state
    input wire logic [23:0] i_addr, // address
    input wire logic [31:0] i_wdata, // write data
    input wire logic i_wr, // write strobe
    input wire logic i_rd, // read strobe
    input wire logic [31:0] o_rdata, // read data
    input wire logic o_tx_valid, // frame offered
    input wire cts_frame_type o_tx, // frame
    input wire logic i_tx_ready // frame taken
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // one read of a place
    sequence s_rd(a);
        i_rd && i_addr == a;
    endsequence
    // write, gap, read back masked
    property p_rw(a, m);
        logic [31:0] v;
        (i_wr && i_addr == a, v = i_wdata) ##2 s_rd(a) |=> (o_rdata & m) == (v & m);
    endproperty
    a_reset_clear: assert property (disable iff (1'b0)
        i_reset |=> !o_tx_valid && o_rdata == 32'h0) else $error("outputs not clear");
    a_frame_stands: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx))
        else $error("offered frame changed");
    a_taken_drops: assert property (o_tx_valid && i_tx_ready |=> !o_tx_valid)
        else $error("taken frame still offered");
    a_op_only: assert property ($rose(o_tx_valid) |-> $past(i_operational))
        else $error("frame while not operational");
    a_last_sub: assert property (i_rd && i_addr[7:0] == 8'h0 &&
        i_addr[23:8] inside {[16'h1800:16'h1807]} |=> o_rdata == 32'h5)
        else $error("last sub-index wrong");
    a_dlc_range: assert property (o_tx_valid |-> o_tx.dlc inside {[4'h1:4'h8]})
        else $error("length out of range");
    a_sync_rw: assert property (p_rw(24'h101500, 32'h7ff))
        else $error("sync identifier not kept");
    a_id_rw: assert property (p_rw(24'h180001, 32'h800007ff))
        else $error("channel identifier not kept");
    a_rd_holds: assert property (!i_rd |=> $stable(o_rdata))
        else $error("read data moved");
    a_unmapped_zero: assert property (s_rd(24'h300000) |=> o_rdata == 32'h0)
        else $error("unmapped read not zero");
endmodule // cts_sched_chk

bind cts_transmit_channel_sched cts_sched_chk u_chk (.i_clk(i_clk), .i_reset(i_reset),
    .i_operational(i_operational), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_tx_valid(o_tx_valid), .o_tx(o_tx),
    .i_tx_ready(i_tx_ready));

// ===== bench/cts_net_model.sv
// Purpose: network stand-in giving sync and remote frames, taking frames
// Assumes: one request pulse gives one received frame
// Notes: idle id and flag toggle so stale values never match
module cts_net_model
    import cts_pkg::*;
(
    input wire logic i_clk, // clock
    input wire logic i_go, // deliver one frame
    input wire logic [10:0] i_go_id, // its identifier
    input wire logic i_go_rtr, // remote request
    input wire logic i_slow, // stall the taker
    output logic o_rx_valid, // frame strobe
    output logic [10:0] o_rx_id, // identifier
    output logic o_rx_rtr, // remote flag
    input wire logic i_tx_valid, // node offers
    input wire cts_frame_type i_tx, // offered frame
    output logic o_tx_ready, // taker ready
    output logic o_got, // frame taken
    output cts_frame_type o_last // last taken frame
);
    logic [1:0] stall_q = 2'h0;
    initial begin
        o_rx_valid = 1'b0;
        o_rx_id = 11'h0;
        o_rx_rtr = 1'b0;
        o_got = 1'b0;
        o_last = 75'h0;
    end
    always @(posedge i_clk) begin
        o_rx_valid <= i_go;
        o_rx_id <= i_go ? i_go_id : ~o_rx_id;
        o_rx_rtr <= i_go ? i_go_rtr : ~o_rx_rtr;
    end
    // taker answers at once or every fourth cycle
    always @(posedge i_clk) begin
        stall_q <= stall_q + 2'h1;
        o_got <= i_tx_valid && o_tx_ready;
        if (i_tx_valid && o_tx_ready) begin
            o_last <= i_tx;
        end
    end
    assign o_tx_ready = !i_slow || stall_q == 2'h0;
endmodule // cts_net_model

// ===== bench/canopen_transmit_channel_sync_scheduler_tb_top.sv
// Purpose: self-checking bench for the transmit channel scheduler
// Assumes: channel 0 carries the traffic; inhibit unit shortened to 20
// Notes: network side stands in cts_net_model
module canopen_transmit_channel_sync_scheduler_tb_top
    import cts_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, op = 1'b1, wr_s = 1'b0, rd_s = 1'b0;
    logic go = 1'b0, go_rtr = 1'b0, slow = 1'b0, rxv, rxr, txv, rdy, got;
    logic [6:0] node = 7'h0;
    logic [10:0] go_id = 11'h0, rxid, cid;
    logic [23:0] addr = 24'h0, old;
    logic [31:0] wdata = 32'h0, rdata, q, seed = 32'h4568;
    logic [511:0] img = 512'h0;
    cts_frame_type tx, last;
    int mismatches = 0, checked = 0, frames = 0, base = 0, cyc = 0, t_prev = 0, t_last = 0;
    cts_transmit_channel_sched #(.INH_UNIT_CYC(20)) dut (.i_clk(clk), .i_reset(rst), .i_node_id(node),
        .i_operational(op), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s),
        .o_rdata(rdata), .i_rx_valid(rxv), .i_rx_id(rxid), .i_rx_rtr(rxr), .i_image(img),
        .o_tx_valid(txv), .o_tx(tx), .i_tx_ready(rdy));
    cts_net_model net (.i_clk(clk), .i_go(go), .i_go_id(go_id), .i_go_rtr(go_rtr),
        .i_slow(slow), .o_rx_valid(rxv), .o_rx_id(rxid), .o_rx_rtr(rxr), .i_tx_valid(txv),
        .i_tx(tx), .o_tx_ready(rdy), .o_got(got), .o_last(last));
    // clock, frame log and hang limit
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (got === 1'b1) begin
            frames = frames + 1;
            t_prev = t_last;
            t_last = cyc;
        end
        if (cyc == 20000) begin
            mismatches = mismatches + 1;
            close_out();
        end
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // payload: image bytes 5, 6 then 16
    function automatic logic [23:0] expd();
        return {img[135:128], img[55:48], img[47:40]};
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked = checked + 1;
        if (g !== e) begin
            mismatches = mismatches + 1;
            $display("[FAIL] %0t value %h expected %h", $time, g, e);
        end
    endtask
    task automatic chkf(input logic [10:0] id, input logic [23:0] d);
        chk({21'h0, last.id}, {21'h0, id}); // frame identifier
        chk({4'h0, last.dlc, last.data[23:0]}, {8'h3, d}); // bytes and length
    endtask
    task automatic wr(input logic [23:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [23:0] a);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 q = rdata;
        @(posedge clk);
    endtask
    task automatic send(input logic [10:0] id, input logic rtr);
        go_id <= id;
        go_rtr <= rtr;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
    endtask
    task automatic expect_n(input int n, input int w);
        repeat (w) @(posedge clk);
        #1;
        if (n >= 0) chk(frames - base, n);
        base = frames;
    endtask
    task automatic close_out();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        q = rnd();
        node = q[6:0];
        for (int k = 0; k < 16; k++) img[32*k +: 32] = rnd();
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int c = 0; c < 8; c++) begin
            rd(24'h180001 + 24'(c) * 24'h100);
            chk(q, c < 4 ? 32'h180 + 32'h100 * c + node : 32'h0); // default ids
            rd(24'h180000 + 24'(c) * 24'h100);
            chk(q, 32'h5); // last sub-index
        end
        rd(24'h180002);
        chk(q, 32'hfe); // default type
        rd(24'h101500);
        chk(q, 32'h80); // sync id default
        rd(24'h1a0000);
        chk(q, 32'h0); // count default
        rd(24'h300000);
        chk(q, 32'h0); // unmapped place reads zero
        wr(24'h1a0001, 32'h20050010); // two bytes at five
        wr(24'h1a0002, 32'h20100008); // one byte at sixteen
        wr(24'h1a0000, 32'h2); // count after entries
        wr(24'h1a0001, rnd()); // write while locked
        rd(24'h1a0001);
        chk(q, 32'h20050010); // entry unchanged
        cid = 11'h180 + node;
        wr(24'h180002, 32'h1);
        send(11'h80, 1'b0);
        expect_n(1, 30); // every sync
        chkf(cid, expd()); // payload order
        wr(24'h180002, 32'h3); // retype restarts count
        repeat (2) send(11'h80, 1'b0);
        expect_n(0, 30); // not before third sync
        send(11'h80, 1'b0);
        expect_n(1, 30); // third sync sends
        wr(24'h180002, 32'h0);
        send(11'h80, 1'b0);
        expect_n(1, 30); // after sync
        send(11'h80, 1'b0);
        expect_n(0, 30); // no repeat without change
        slow <= 1'b1;
        wr(24'h180002, 32'hfc);
        send(11'h80, 1'b0);
        expect_n(0, 30); // latch only
        old = expd();
        img[47:40] = ~img[47:40];
        send(cid, 1'b1);
        expect_n(1, 30); // remote sends latch
        chkf(cid, old); // latched payload
        wr(24'h180002, 32'hfd);
        send(cid, 1'b1);
        expect_n(1, 30); // remote sends fresh
        chkf(cid, expd()); // fresh payload
        slow <= 1'b0;
        wr(24'h180002, 32'hfe);
        wr(24'h180005, 32'h1); // one millisecond
        // line the count window up with the free-running millisecond tick
        @(posedge clk iff got === 1'b1);
        expect_n(-1, 1);
        expect_n(2, 400); // period of 200 cycles
        chk(t_last - t_prev, 20 * CTS_INH_PER_MS); // one millisecond apart
        wr(24'h180005, 32'h0);
        wr(24'h180002, 32'hff);
        expect_n(-1, 30);
        img[135:128] = ~img[135:128];
        expect_n(1, 30); // change sends
        expect_n(0, 30); // no change no frame
        wr(24'h180002, 32'h1);
        wr(24'h180003, 32'h2); // two units
        repeat (2) send(11'h80, 1'b0);
        expect_n(2, 100); // deferred not lost
        chk({31'h0, t_last - t_prev >= 40}, 32'h1); // gap kept
        wr(24'h180003, 32'h0);
        op <= 1'b0;
        send(11'h80, 1'b0);
        expect_n(0, 30); // silent when not operational
        op <= 1'b1;
        wr(24'h101500, 32'h91);
        rd(24'h101500);
        chk(q, 32'h91); // identifier reads back
        send(11'h80, 1'b0);
        expect_n(0, 30); // old sync id ignored
        send(11'h91, 1'b0);
        expect_n(1, 30); // new sync id
        q = rnd();
        cid = q[10:0];
        wr(24'h180001, {1'b1, 20'h0, cid});
        rd(24'h180001);
        chk(q, {1'b1, 20'h0, cid}); // stored fields
        send(11'h91, 1'b0);
        expect_n(0, 30); // disabled channel silent
        wr(24'h180001, {21'h0, cid});
        expect_n(1, 30); // sync held while disabled goes out
        send(11'h91, 1'b0);
        expect_n(1, 30); // new identifier
        chkf(cid, expd()); // frame carries it
        wr(24'h1a0000, 32'h0);
        send(11'h91, 1'b0);
        expect_n(0, 30); // zero count disables
        close_out();
    end
endmodule // canopen_transmit_channel_sync_scheduler_tb_top
